//--- core/gmbc_pkg.sv
// Constants for the output pin selector and band calibration status register bank
//
// Overview of operation
// RULE1 - Five-bit output selector, reset to one, picks the signal for the data-out pin.
// RULE2 - Codes 0..7: test bit, lock detect out/trigger/window, ring osc, slip pulls, reserved.
// RULE3 - Codes 8..15: reference buffer/divider, osc divider, clocks, auxiliary serial signals.
// RULE4 - Codes 16..25: detector down/up, modulator clocks, autostrobes, latch, sync, seed.
// RULE5 - Codes 26..29 unused; 30 is output buffer enable; 31 is soft reset low.
// RULE6 - Bit 6 set: pin carries general output only; clear: auto-switch with read data.
// RULE7 - Bit 7 set: pin driver always on; clear: on only during serial read.
// RULE8 - Eight-bit read-only band field, reset 32, holds calibration's chosen switch setting.
// RULE9 - Host ignores band field while busy bit 8 reads one.
// RULE10 - Band field updates from calibration result only, never from manual override.
// RULE11 - Band value zero is highest frequency; larger values mean lower bands.
// RULE12 - Upper band bits unused by the oscillator carry no meaning.
// RULE13 - Busy bit 8 is high exactly while calibration searches. The code registers it, so it rises and falls one cycle after the search does.
// RULE14 - Reads return fields with upper bits zero; writes to status register ignored.
package gmbc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 24;
  localparam logic [5:0]  OFS_PIN_CFG     = 6'h0F;
  localparam logic [5:0]  OFS_BAND_STAT   = 6'h10;

  // ---------------------------------------------------------------
  // Config register fields
  // ---------------------------------------------------------------
  localparam int          CFG_W           = 10;
  localparam logic [9:0]  CFG_RESET       = 10'h001;
  localparam int          SEL_LSB         = 0;
  localparam int          SEL_W           = 5;
  localparam int          TEST_BIT        = 5;
  localparam int          NO_SHARE_BIT    = 6;
  localparam int          FORCE_ON_BIT    = 7;
  localparam int          PULLUP_OFF_BIT  = 8;
  localparam int          PULLDN_OFF_BIT  = 9;

  // ---------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------
  localparam int          BAND_W          = 8;
  localparam logic [7:0]  BAND_RESET      = 8'h20;
  localparam int          BUSY_BIT        = 8;

  // ---------------------------------------------------------------
  // Selector codes with special handling
  // ---------------------------------------------------------------
  localparam int          NUM_SRC         = 32;
  localparam logic [4:0]  SEL_TEST_DATA   = 5'h00;
  localparam logic [4:0]  SEL_RESERVED    = 5'h07;
  localparam logic [4:0]  SEL_UNUSED_LO   = 5'h1A;
  localparam logic [4:0]  SEL_UNUSED_HI   = 5'h1D;
  localparam logic [4:0]  SEL_BUF_EN      = 5'h1E;
  localparam logic [4:0]  SEL_SOFT_RST    = 5'h1F;

endpackage

//--- core/gmbc_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous source signals
`timescale 1ns/1ns
module gmbc_sync #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // ---------------------------------------------------------------
  // Capture chain; stage one feeds only stage two
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ---------------------------------------------------------------
  // Accept a bit only once stages two and three agree
  // ---------------------------------------------------------------
  // Per-bit filter rejects a single metastable sample
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

//--- core/gmbc_regs.sv
// Output pin selector, pin sharing control and band calibration status registers
`timescale 1ns/1ns
module gmbc_regs (
  // Clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         nrst_in,
  // Register port from the serial engine
  input  wire logic                         reg_wr_en_in,
  input  wire logic                         reg_rd_en_in,
  input  wire logic [gmbc_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [gmbc_pkg::DATA_W-1:0]  reg_wdata_in,
  output logic      [gmbc_pkg::DATA_W-1:0]  reg_rdata_out,
  // Serial read cycle from the serial engine
  input  wire logic                         read_active_in,
  input  wire logic                         read_data_in,
  // Internal sources, asynchronous; index equals selector code
  input  wire logic [gmbc_pkg::NUM_SRC-1:0] gpo_sources_in,
  input  wire logic                         soft_reset_low_in,
  // Automatic band calibration
  input  wire logic                         cal_busy_in,
  input  wire logic                         cal_done_in,
  input  wire logic [gmbc_pkg::BAND_W-1:0]  cal_band_in,
  // Shared lock and serial out pin
  output logic                              pin_out,
  output logic                              pin_oe_out,
  // Driver transistor controls
  output logic                              pullup_transistor_off_out,
  output logic                              pulldown_transistor_off_out
);

  logic [gmbc_pkg::CFG_W-1:0]   cfg_q;
  logic [gmbc_pkg::BAND_W-1:0]  band_q;
  logic                         busy_q;
  logic [gmbc_pkg::NUM_SRC-1:0] src_sync;
  logic [gmbc_pkg::NUM_SRC-1:0] src_raw;
  logic [gmbc_pkg::SEL_W-1:0]   sel;
  logic                         gpo_d;
  logic                         gpo_q;
  logic                         hit_cfg;
  logic                         hit_stat;

  assign sel      = cfg_q[gmbc_pkg::SEL_LSB +: gmbc_pkg::SEL_W];
  assign hit_cfg  = (reg_addr_in == gmbc_pkg::OFS_PIN_CFG);
  assign hit_stat = (reg_addr_in == gmbc_pkg::OFS_BAND_STAT);

  // ---------------------------------------------------------------
  // Source synchronisation
  // ---------------------------------------------------------------
  // Soft reset rides in the top slot with the other asynchronous sources
  always_comb begin
    src_raw                        = gpo_sources_in;
    src_raw[gmbc_pkg::SEL_SOFT_RST] = soft_reset_low_in;
  end

  gmbc_sync #(
    .WIDTH (gmbc_pkg::NUM_SRC)
  ) u_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .async_in (src_raw),
    .sync_out (src_sync)
  );

  // ---------------------------------------------------------------
  // Configuration register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cfg_q <= gmbc_pkg::CFG_RESET; // RULE1
    end else if (reg_wr_en_in && hit_cfg) begin
      cfg_q <= reg_wdata_in[gmbc_pkg::CFG_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Band calibration status
  // ---------------------------------------------------------------
  // Only the calibration result loads the field; writes never reach it
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      band_q <= gmbc_pkg::BAND_RESET; // RULE8
    end else if (cal_done_in) begin
      band_q <= cal_band_in; // RULE10 RULE11 RULE12
    end
  end

  // Busy mirrors the searching state with one register stage
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      busy_q <= 1'h0;
    end else begin
      busy_q <= cal_busy_in; // RULE13
    end
  end

  // ---------------------------------------------------------------
  // General output selector
  // ---------------------------------------------------------------
  always_comb begin
    if (sel == gmbc_pkg::SEL_TEST_DATA) begin
      gpo_d = cfg_q[gmbc_pkg::TEST_BIT]; // RULE2
    end else if (sel == gmbc_pkg::SEL_RESERVED) begin
      gpo_d = 1'h0; // RULE2
    end else if (sel >= gmbc_pkg::SEL_UNUSED_LO && sel <= gmbc_pkg::SEL_UNUSED_HI) begin
      gpo_d = 1'h0; // RULE5
    end else if (sel == gmbc_pkg::SEL_BUF_EN) begin
      gpo_d = pin_oe_out; // RULE5
    end else begin
      gpo_d = src_sync[sel]; // RULE2 RULE3 RULE4 RULE5
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      gpo_q <= 1'h0;
    end else begin
      gpo_q <= gpo_d;
    end
  end

  // ---------------------------------------------------------------
  // Pin data and driver enable
  // ---------------------------------------------------------------
  // Read data path passes one register stage, the general output two
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pin_out <= 1'h0;
    end else if (cfg_q[gmbc_pkg::NO_SHARE_BIT] || !read_active_in) begin
      pin_out <= gpo_q; // RULE6
    end else begin
      pin_out <= read_data_in; // RULE6
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pin_oe_out <= 1'h0;
    end else begin
      pin_oe_out <= cfg_q[gmbc_pkg::FORCE_ON_BIT] || read_active_in; // RULE7
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pullup_transistor_off_out   <= 1'h0;
      pulldown_transistor_off_out <= 1'h0;
    end else begin
      pullup_transistor_off_out   <= cfg_q[gmbc_pkg::PULLUP_OFF_BIT];
      pulldown_transistor_off_out <= cfg_q[gmbc_pkg::PULLDN_OFF_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Unmapped addresses read zero; data holds until the next read
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_en_in) begin
      if (hit_cfg) begin
        reg_rdata_out <= {{(gmbc_pkg::DATA_W-gmbc_pkg::CFG_W){1'h0}}, cfg_q}; // RULE14
      end else if (hit_stat) begin
        reg_rdata_out <= {{(gmbc_pkg::DATA_W-gmbc_pkg::BAND_W-1){1'h0}}, busy_q, band_q}; // RULE14 RULE9
      end else begin
        reg_rdata_out <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_cal_done;
    cal_done_in ##1 1'h1;
  endsequence

  a_cfg_reset_value: assert property (!$past(nrst_in) |-> cfg_q == gmbc_pkg::CFG_RESET) // RULE1
    else $error("config not at reset value after reset");
  a_sel_test_data: assert property (sel == gmbc_pkg::SEL_TEST_DATA |=> gpo_q == $past(cfg_q[gmbc_pkg::TEST_BIT])) // RULE2
    else $error("test data bit not routed");
  a_sel_reserved_low: assert property (sel == gmbc_pkg::SEL_RESERVED |=> !gpo_q) // RULE2
    else $error("reserved selector not low");
  a_sel_mid_route: assert property (sel == 5'h09 |=> gpo_q == $past(src_sync[9])) // RULE3
    else $error("reference divider not routed");
  a_sel_high_route: assert property (sel == 5'h18 |=> gpo_q == $past(src_sync[24])) // RULE4
    else $error("divider sync reset not routed");
  a_sel_unused_low: assert property (sel >= gmbc_pkg::SEL_UNUSED_LO && sel <= gmbc_pkg::SEL_UNUSED_HI |=> !gpo_q) // RULE5
    else $error("unused selector not low");
  a_sel_buf_en: assert property (sel == gmbc_pkg::SEL_BUF_EN |=> gpo_q == $past(pin_oe_out)) // RULE5
    else $error("buffer enable not routed");
  a_pin_no_share: assert property (cfg_q[gmbc_pkg::NO_SHARE_BIT] |=> pin_out == $past(gpo_q)) // RULE6
    else $error("pin shared while sharing disabled");
  a_pin_auto_read: assert property (!cfg_q[gmbc_pkg::NO_SHARE_BIT] && read_active_in
                                    |=> pin_out == $past(read_data_in)) // RULE6
    else $error("read data not on pin");
  a_drv_force_on: assert property (cfg_q[gmbc_pkg::FORCE_ON_BIT] |=> pin_oe_out) // RULE7
    else $error("driver off while forced on");
  a_drv_idle_off: assert property (!cfg_q[gmbc_pkg::FORCE_ON_BIT] && !read_active_in |=> !pin_oe_out) // RULE7
    else $error("driver on outside read");
  a_band_load: assert property (s_cal_done |-> band_q == $past(cal_band_in)) // RULE8
    else $error("band not loaded from calibration");
  a_band_hold: assert property (!cal_done_in |=> $stable(band_q)) // RULE10
    else $error("band changed without calibration result");
  a_busy_follow: assert property (cal_busy_in [*2] |-> busy_q) // RULE13
    else $error("busy flag not following calibration");
  a_stat_read: assert property (reg_rd_en_in && hit_stat
                                |=> reg_rdata_out == {15'h0000, $past(busy_q), $past(band_q)}) // RULE14
    else $error("status read data wrong");
  a_cfg_read: assert property (reg_rd_en_in && hit_cfg |=> reg_rdata_out == {14'h0, $past(cfg_q)}) // RULE14
    else $error("config read data wrong");
  a_cfg_write: assert property (reg_wr_en_in && hit_cfg
                                |=> cfg_q == $past(reg_wdata_in[gmbc_pkg::CFG_W-1:0])) // RULE1
    else $error("config write not stored");
  // Writes elsewhere, the status register included, must leave the config alone
  a_cfg_no_stray: assert property (!(reg_wr_en_in && hit_cfg) |=> $stable(cfg_q)) // RULE14
    else $error("config changed without config write");
  a_sel_soft_rst: assert property (sel == gmbc_pkg::SEL_SOFT_RST
                                   |=> gpo_q == $past(src_sync[gmbc_pkg::SEL_SOFT_RST])) // RULE5
    else $error("soft reset level not routed");
  a_busy_drop: assert property ((!cal_busy_in) [*2] |-> !busy_q) // RULE13
    else $error("busy flag high while not searching");

endmodule

//--- tb/gmbc_host_model.sv
// Host side model: register strobe port and serial read cycles of the serial engine
`timescale 1ns/1ns
module gmbc_host_model (
  // Clock
  input  wire logic                        clk_in,
  // Register strobe port
  output logic                             wr_en_out,
  output logic                             rd_en_out,
  output logic [gmbc_pkg::ADDR_W-1:0]      addr_out,
  output logic [gmbc_pkg::DATA_W-1:0]      wdata_out,
  // Serial read cycle
  output logic                             rd_active_out,
  output logic                             rd_data_out
);
  // ---------------------------------------------------------------
  // Idle state and transfer tasks
  // ---------------------------------------------------------------
  // Released address, write data and read data lines show the inverse of the last value; strobes and read cycle drop low
  initial begin
    wr_en_out = 1'h0;
    rd_en_out = 1'h0;
    addr_out = 6'h00;
    wdata_out = 24'h000000;
    rd_active_out = 1'h0;
    rd_data_out = 1'h0;
  end
  // One strobe per access, held through the edge that takes it
  task automatic access(input logic wr, input logic [5:0] a, input logic [23:0] d);
    @(posedge clk_in);
    wr_en_out <= wr;
    rd_en_out <= ~wr;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'h0;
    rd_en_out <= 1'h0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  // Read cycle framing; the caller decides how long it stays open
  task automatic serial_start(input logic b);
    @(posedge clk_in);
    rd_active_out <= 1'h1;
    rd_data_out <= b;
  endtask
  task automatic serial_stop();
    @(posedge clk_in);
    rd_active_out <= 1'h0;
    rd_data_out <= ~rd_data_out;
  endtask
endmodule

//--- tb/gmbc_tb_top.sv
// Self-checking bench for the output selector and band status register bank
`timescale 1ns/1ns
module gmbc_tb_top;
  // ---------------------------------------------------------------
  // Signals and checking helpers
  // ---------------------------------------------------------------
  logic        clk_in, nrst_in, wr, rd, ract, rdat, srst, busy, done, pin, oe, pup_off, pdn_off, rd_pend, e;
  logic [5:0]  addr;
  logic [23:0] wdata, rdata;
  logic [31:0] src;
  logic [7:0]  band;
  logic [15:0] lf;
  logic [47:0] note;
  logic [47:0] notes[$];
  int          err_total, num_checks;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [23:0] x, input logic [23:0] s);
    num_checks++;
    if (x !== s) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask
  // Expected read word and mask are noted before the strobe goes out
  task automatic rd_exp(input logic [5:0] a, input logic [23:0] x, input logic [23:0] m);
    notes.push_back({m, x});
    host.access(1'h0, a, 24'h000000);
  endtask
  task automatic pin_chk(input logic xo, input logic xp);
    @(negedge clk_in);
    chk("pin_oe_out", {23'h0, xo}, {23'h0, oe});
    chk("pin_out", {23'h0, xp}, {23'h0, pin});
  endtask
  task automatic wrap_up();
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  gmbc_host_model host (.clk_in(clk_in), .wr_en_out(wr), .rd_en_out(rd), .addr_out(addr), .wdata_out(wdata),
    .rd_active_out(ract), .rd_data_out(rdat));
  gmbc_regs DUT (.clk_in(clk_in), .nrst_in(nrst_in), .reg_wr_en_in(wr), .reg_rd_en_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .read_active_in(ract), .read_data_in(rdat),
    .gpo_sources_in(src), .soft_reset_low_in(srst), .cal_busy_in(busy), .cal_done_in(done),
    .cal_band_in(band), .pin_out(pin), .pin_oe_out(oe), .pullup_transistor_off_out(pup_off),
    .pulldown_transistor_off_out(pdn_off));
  // ---------------------------------------------------------------
  // Clock, monitor and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_in = 1'h0;
    forever #20 clk_in = ~clk_in;
  end
  // Read word appears the cycle after its strobe; oldest note is matched
  always @(posedge clk_in) begin
    rd_pend <= rd;
    if (rd_pend === 1'h1) begin
      note = notes.pop_front();
      chk("reg_rdata_out", note[23:0], rdata & note[47:24]);
    end
  end
  // About twenty-five times the expected run length
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    {nrst_in, srst, busy, done} = 4'h0;
    src = 32'h00000000;
    band = 8'h00;
    lf = 16'h0026;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'h1;
    rd_exp(gmbc_pkg::OFS_PIN_CFG, 24'h000001, 24'hFFFFFF);
    rd_exp(gmbc_pkg::OFS_BAND_STAT, 24'h000020, 24'hFFFFFF);
    rd_exp(6'h11, 24'h000000, 24'hFFFFFF);
    host.access(1'h1, gmbc_pkg::OFS_PIN_CFG, 24'hFFFFFF);
    rd_exp(gmbc_pkg::OFS_PIN_CFG, 24'h0003FF, 24'hFFFFFF);
    pin_chk(1'h1, 1'h0);
    chk("transistor offs", 24'h000003, {22'h0, pdn_off, pup_off});
    // Every selector code with fresh random sources, shared path disabled
    for (int c = 0; c < 32; c++) begin
      lf = lfsr(lfsr(lf));
      host.access(1'h1, gmbc_pkg::OFS_PIN_CFG, {17'h0, 1'h1, lf[0], c[4:0]});
      src <= {lf, lfsr(lf)};
      srst <= lf[3];
      repeat (8) @(posedge clk_in);
      if (c == 0)
        e = lf[0];
      else if (c == 7 || c >= 26 && c <= 30)
        e = 1'h0;
      else if (c == 31)
        e = srst;
      else
        e = src[c];
      pin_chk(1'h0, e);
    end
    // Auto-share: read data only while a read cycle runs
    host.access(1'h1, gmbc_pkg::OFS_PIN_CFG, 24'h000004);
    src <= 32'h00000010;
    host.serial_start(1'h0);
    repeat (8) @(posedge clk_in);
    pin_chk(1'h1, 1'h0);
    host.serial_stop();
    repeat (2) @(posedge clk_in);
    pin_chk(1'h0, 1'h1);
    host.access(1'h1, gmbc_pkg::OFS_PIN_CFG, 24'h000044);
    host.serial_start(1'h0);
    repeat (2) @(posedge clk_in);
    pin_chk(1'h1, 1'h1);
    host.serial_stop();
    host.access(1'h1, gmbc_pkg::OFS_PIN_CFG, 24'h00009E);
    repeat (8) @(posedge clk_in);
    pin_chk(1'h1, 1'h1);
    // Calibration: band masked while searching, then loaded on completion
    @(posedge clk_in);
    busy <= 1'h1;
    repeat (2) @(posedge clk_in);
    rd_exp(gmbc_pkg::OFS_BAND_STAT, 24'h000100, 24'h000100);
    host.access(1'h1, gmbc_pkg::OFS_BAND_STAT, 24'hFFFFFF);
    busy <= 1'h0;
    done <= 1'h1;
    band <= lf[15:8];
    @(posedge clk_in);
    done <= 1'h0;
    band <= ~lf[15:8];
    rd_exp(gmbc_pkg::OFS_BAND_STAT, {16'h0, lf[15:8]}, 24'hFFFFFF);
    repeat (3) @(posedge clk_in);
    wrap_up();
  end
endmodule
